// ===== hw/ccsp_pkg.sv
// Constants, register map and field layout of the control and status pin block
`default_nettype none
package ccsp_pkg;
  localparam int unsigned ADDR_W      = 16;
  localparam int unsigned IDX_W       = 14;
  localparam int unsigned NUM_OUT_DEF = 10;
  localparam int unsigned NUM_IN      = 4;
  localparam int unsigned SEL_W       = 4;

  // Register indices; the byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CTRL      = 14'h0000;
  localparam logic [IDX_W-1:0] IDX_STEP      = 14'h0001;
  localparam logic [IDX_W-1:0] IDX_STATUS    = 14'h0002;
  localparam logic [IDX_W-1:0] IDX_CHANGE    = 14'h0003;
  localparam logic [IDX_W-1:0] IDX_FREQ_BASE = 14'h0010;
  localparam logic [IDX_W-1:0] IDX_IO_LEVEL  = 14'h0943;

  // Control register fields
  localparam int unsigned CTRL_OUT_EN_LSB = 0;
  localparam int unsigned CTRL_MANUAL_BIT = 16;
  localparam logic [31:0] CTRL_RESET      = 32'h0001_03ff;

  // Step register fields
  localparam int unsigned STEP_SEL_LSB  = 0;
  localparam int unsigned STEP_SIZE_LSB = 8;
  localparam int unsigned STEP_SIZE_W   = 16;
  localparam logic [31:0] STEP_RESET    = 32'h0000_0100;

  // Status vector: lock, four inputs present, reference present
  localparam int unsigned STAT_W        = 6;
  localparam int unsigned STAT_LOCK_BIT = 0;
  localparam int unsigned STAT_IN_LSB   = 1;
  localparam int unsigned STAT_REF_BIT  = 5;
  localparam int unsigned STAT_LSB      = 0;
  localparam int unsigned ACT_LSB       = 8;

  localparam int unsigned IO_LEVEL_BIT   = 0;
  localparam logic        IO_LEVEL_RESET = 1'b0;
  localparam logic [31:0] FREQ_RESET_DEF = 32'h1000_0000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ===== hw/ccsp_pin_sync.sv
// Two-flop synchroniser for levels arriving from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module ccsp_pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,       // Block clock
  input  wire logic             resetn,    // Async reset, active low
  input  wire logic [WIDTH-1:0] async_in,  // Unsynchronised levels
  output logic      [WIDTH-1:0] sync_out   // Levels safe to use
);
  logic [WIDTH-1:0] meta_reg;

  // First stage is read only by the second stage
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule // ccsp_pin_sync
`default_nettype wire

// ===== hw/ccsp_rise_pulse.sv
// Rising-edge detector giving a one-cycle pulse per edge of a synchronised level
`timescale 1ns/100ps
`default_nettype none
module ccsp_rise_pulse #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,       // Block clock
  input  wire logic             resetn,    // Async reset, active low
  input  wire logic [WIDTH-1:0] level_in,  // Synchronised levels
  output logic      [WIDTH-1:0] pulse_out  // One pulse per rising edge
);
  logic [WIDTH-1:0] prev_reg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= level_in;
    end
  end

  // Level held high gives no further pulse
  assign pulse_out = level_in & ~prev_reg;
endmodule // ccsp_rise_pulse
`default_nettype wire

// ===== hw/ccsp_top.sv
// Control and status pin logic with AXI4-Lite register access
`timescale 1ns/100ps
`default_nettype none
module ccsp_top
  import ccsp_pkg::*;
#(
  parameter int unsigned NUM_OUT    = NUM_OUT_DEF,
  parameter logic [31:0] FREQ_RESET = FREQ_RESET_DEF
) (
  input  wire logic                  CLK,                      // 200 MHz clock
  input  wire logic                  RESETN,                   // Reset pin, active low
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0]     S_AXI_AWADDR,             // Write address
  input  wire logic                  S_AXI_AWVALID,            // Write address valid
  output logic                       S_AXI_AWREADY,            // Write address ready
  input  wire logic [31:0]           S_AXI_WDATA,              // Write data
  input  wire logic [3:0]            S_AXI_WSTRB,              // Write byte strobes
  input  wire logic                  S_AXI_WVALID,             // Write data valid
  output logic                       S_AXI_WREADY,             // Write data ready
  output logic [1:0]                 S_AXI_BRESP,              // Write response
  output logic                       S_AXI_BVALID,             // Write response valid
  input  wire logic                  S_AXI_BREADY,             // Write response ready
  input  wire logic [ADDR_W-1:0]     S_AXI_ARADDR,             // Read address
  input  wire logic                  S_AXI_ARVALID,            // Read address valid
  output logic                       S_AXI_ARREADY,            // Read address ready
  output logic [31:0]                S_AXI_RDATA,              // Read data
  output logic [1:0]                 S_AXI_RRESP,              // Read response
  output logic                       S_AXI_RVALID,             // Read data valid
  input  wire logic                  S_AXI_RREADY,             // Read data ready
  // Control pins
  input  wire logic                  OUTPUT_DISABLE_IN,        // High turns all outputs off
  input  wire logic                  FREQ_STEP_UP_IN,          // Step-up request pin
  input  wire logic                  FREQ_STEP_DOWN_IN,        // Step-down request pin
  input  wire logic                  INPUT_CHOICE_BIT0,        // Input choice, low bit
  input  wire logic                  INPUT_CHOICE_BIT1,        // Input choice, high bit
  // Status from the loop and input monitors
  input  wire logic                  PLL_LOCKED_IN,            // Loop locked
  input  wire logic [NUM_IN-1:0]     INPUT_CLK_PRESENT_IN,     // Clock seen per input
  input  wire logic                  REFERENCE_PRESENT_IN,     // Signal seen on reference
  // Status pins
  output logic                       STATUS_CHANGE_IRQ_N,      // Low after a status change
  output logic                       PLL_LOCK_INDICATOR,       // High while locked
  output logic                       INPUT0_SIGNAL_LOST_N,     // Low while input 0 lost
  output logic                       INPUT1_SIGNAL_LOST_N,     // Low while input 1 lost
  output logic                       INPUT2_SIGNAL_LOST_N,     // Low while input 2 lost
  output logic                       INPUT3_SIGNAL_LOST_N,     // Low while input 3 lost
  output logic                       REFERENCE_SIGNAL_LOST_N,  // Low while reference lost
  // Towards the output drivers and synthesis core
  output logic [NUM_OUT-1:0]         CLK_OUT_ENABLE,           // Per-output driver enable
  output logic [1:0]                 ACTIVE_INPUT,             // Chosen clock input
  output logic                       IO_LEVEL_1V8,             // Pin levels: 1 = 1.8 V
  output logic [NUM_OUT*32-1:0]      OUT_FREQ_WORDS            // Frequency words, out 0 low
);

  // ----------------------------------------------------------------
  // Pin and status synchronisation
  // ----------------------------------------------------------------
  logic [4:0]        pins_s;
  logic [STAT_W-1:0] stat_s;
  logic [1:0]        step_pulse;
  logic              oe_off_s;
  logic              up_pulse;
  logic              down_pulse;
  logic [1:0]        choice_s;

  ccsp_pin_sync #(.WIDTH(5)) u_pin_sync (
    .clk      (CLK),
    .resetn   (RESETN),
    .async_in ({INPUT_CHOICE_BIT1, INPUT_CHOICE_BIT0, FREQ_STEP_DOWN_IN,
                FREQ_STEP_UP_IN, OUTPUT_DISABLE_IN}),
    .sync_out (pins_s)
  );

  ccsp_pin_sync #(.WIDTH(STAT_W)) u_stat_sync (
    .clk      (CLK),
    .resetn   (RESETN),
    .async_in ({REFERENCE_PRESENT_IN, INPUT_CLK_PRESENT_IN, PLL_LOCKED_IN}),
    .sync_out (stat_s)
  );

  ccsp_rise_pulse #(.WIDTH(2)) u_step_edge (
    .clk       (CLK),
    .resetn    (RESETN),
    .level_in  (pins_s[2:1]),
    .pulse_out (step_pulse)
  );

  assign oe_off_s   = pins_s[0];
  assign up_pulse   = step_pulse[0];
  assign down_pulse = step_pulse[1];
  assign choice_s   = pins_s[4:3];

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  logic                aw_held_reg;
  logic                w_held_reg;
  logic [ADDR_W-1:0]   awaddr_reg;
  logic [31:0]         wdata_reg;
  logic [3:0]          wstrb_reg;
  logic                bvalid_reg;
  logic [1:0]          bresp_reg;
  logic                wr_fire;
  logic [IDX_W-1:0]    wr_idx;

  function automatic logic idx_mapped(input logic [IDX_W-1:0] idx);
    return (idx == IDX_CTRL) || (idx == IDX_STEP) || (idx == IDX_STATUS) ||
           (idx == IDX_CHANGE) || (idx == IDX_IO_LEVEL) ||
           ((idx >= IDX_FREQ_BASE) && (idx < IDX_FREQ_BASE + IDX_W'(NUM_OUT)));
  endfunction

  function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Address and data may arrive in either order; each is held until both are in
  assign S_AXI_AWREADY = !aw_held_reg && !bvalid_reg;
  assign S_AXI_WREADY  = !w_held_reg && !bvalid_reg;
  assign wr_fire       = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_idx        = awaddr_reg[ADDR_W-1:2];
  assign S_AXI_BVALID  = bvalid_reg;
  assign S_AXI_BRESP   = bresp_reg;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= '0;
      wstrb_reg   <= '0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= S_AXI_WDATA;
        wstrb_reg  <= S_AXI_WSTRB;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= idx_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && S_AXI_BREADY) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [31:0]            ctrl_reg;
  logic [31:0]            step_reg;
  logic                   io_level_reg;
  logic [SEL_W-1:0]       step_sel;
  logic [31:0]            step_ext;
  logic                   sel_ok;
  logic                   manual_mode;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_fire && wr_idx == IDX_CTRL) begin
      ctrl_reg <= apply_strb(ctrl_reg, wdata_reg, wstrb_reg);
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      step_reg <= STEP_RESET;
    end else if (wr_fire && wr_idx == IDX_STEP) begin
      step_reg <= apply_strb(step_reg, wdata_reg, wstrb_reg);
    end
  end

  // Level choice reaches the pad cells and the bus read-back; no other logic here depends on it
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      io_level_reg <= IO_LEVEL_RESET;
    end else if (wr_fire && wr_idx == IDX_IO_LEVEL && wstrb_reg[0]) begin
      io_level_reg <= wdata_reg[IO_LEVEL_BIT];
    end
  end
  assign IO_LEVEL_1V8 = io_level_reg;

  assign step_sel    = step_reg[STEP_SEL_LSB +: SEL_W];
  assign step_ext    = 32'(step_reg[STEP_SIZE_LSB +: STEP_SIZE_W]);
  assign sel_ok      = step_sel < SEL_W'(NUM_OUT);
  assign manual_mode = ctrl_reg[CTRL_MANUAL_BIT];

  // ----------------------------------------------------------------
  // Frequency words and pin steps
  // ----------------------------------------------------------------
  logic [31:0] freq_reg [NUM_OUT];
  logic [31:0] sel_word;

  // A bus write to the same word wins; opposite requests together cancel
  for (genvar g = 0; g < NUM_OUT; g++) begin : g_freq
    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        freq_reg[g] <= FREQ_RESET;
      end else if (wr_fire && wr_idx == IDX_FREQ_BASE + IDX_W'(g)) begin
        freq_reg[g] <= apply_strb(freq_reg[g], wdata_reg, wstrb_reg);
      end else if (step_sel == SEL_W'(g)) begin
        if (up_pulse && !down_pulse) begin
          freq_reg[g] <= freq_reg[g] + step_ext;
        end else if (down_pulse && !up_pulse) begin
          freq_reg[g] <= freq_reg[g] - step_ext;
        end
      end
    end
    assign OUT_FREQ_WORDS[g*32 +: 32] = freq_reg[g];
  end

  assign sel_word = sel_ok ? freq_reg[step_sel] : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Input choice and output enables
  // ----------------------------------------------------------------
  logic [1:0] active_reg;

  function automatic logic [1:0] first_present(input logic [NUM_IN-1:0] present,
                                               input logic [1:0]        keep);
    logic [1:0] res;
    res = keep;
    for (int i = NUM_IN - 1; i >= 0; i--) begin
      if (present[i]) begin
        res = 2'(i);
      end
    end
    return res;
  endfunction

  // Automatic mode keeps the current input when none is present
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      active_reg <= 2'h0;
    end else if (manual_mode) begin
      active_reg <= choice_s;
    end else begin
      active_reg <= first_present(stat_s[STAT_IN_LSB +: NUM_IN], active_reg);
    end
  end
  assign ACTIVE_INPUT = active_reg;

  // Flop resets to zero, so outputs stay off for the whole reset
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      CLK_OUT_ENABLE <= '0;
    end else if (oe_off_s) begin
      CLK_OUT_ENABLE <= '0;
    end else begin
      CLK_OUT_ENABLE <= ctrl_reg[CTRL_OUT_EN_LSB +: NUM_OUT];
    end
  end

  // ----------------------------------------------------------------
  // Status pins and change flags
  // ----------------------------------------------------------------
  logic [STAT_W-1:0] stat_prev_reg;
  logic [STAT_W-1:0] change_reg;
  logic [STAT_W-1:0] change_vec;
  logic [STAT_W-1:0] clear_vec;
  logic              irq_n_reg;

  assign change_vec = stat_s ^ stat_prev_reg;
  assign clear_vec  = (wr_fire && wr_idx == IDX_CHANGE && wstrb_reg[0]) ?
                      wdata_reg[STAT_W-1:0] : '0;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      stat_prev_reg <= '0;
    end else begin
      stat_prev_reg <= stat_s;
    end
  end

  // A change in the same cycle as its clear keeps the flag set
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      change_reg <= '0;
    end else begin
      change_reg <= (change_reg & ~clear_vec) | change_vec;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      irq_n_reg <= 1'b1;
    end else begin
      irq_n_reg <= ~(|change_reg);
    end
  end
  assign STATUS_CHANGE_IRQ_N = irq_n_reg;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      PLL_LOCK_INDICATOR      <= 1'b0;
      INPUT0_SIGNAL_LOST_N    <= 1'b0;
      INPUT1_SIGNAL_LOST_N    <= 1'b0;
      INPUT2_SIGNAL_LOST_N    <= 1'b0;
      INPUT3_SIGNAL_LOST_N    <= 1'b0;
      REFERENCE_SIGNAL_LOST_N <= 1'b0;
    end else begin
      PLL_LOCK_INDICATOR      <= stat_s[STAT_LOCK_BIT];
      INPUT0_SIGNAL_LOST_N    <= stat_s[STAT_IN_LSB];
      INPUT1_SIGNAL_LOST_N    <= stat_s[STAT_IN_LSB + 1];
      INPUT2_SIGNAL_LOST_N    <= stat_s[STAT_IN_LSB + 2];
      INPUT3_SIGNAL_LOST_N    <= stat_s[STAT_IN_LSB + 3];
      REFERENCE_SIGNAL_LOST_N <= stat_s[STAT_REF_BIT];
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  logic [IDX_W-1:0] ar_idx;
  logic [SEL_W-1:0] freq_rd_sel;
  logic [31:0]      status_word;
  logic [31:0]      rd_word;
  logic             rvalid_reg;
  logic [31:0]      rdata_reg;
  logic [1:0]       rresp_reg;

  assign ar_idx        = S_AXI_ARADDR[ADDR_W-1:2];
  assign freq_rd_sel   = SEL_W'(ar_idx - IDX_FREQ_BASE);
  assign S_AXI_ARREADY = !rvalid_reg;
  assign S_AXI_RVALID  = rvalid_reg;
  assign S_AXI_RDATA   = rdata_reg;
  assign S_AXI_RRESP   = rresp_reg;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[STAT_LSB +: STAT_W] = stat_s;
    status_word[ACT_LSB +: 2] = active_reg;
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    if (ar_idx == IDX_CTRL) begin
      rd_word = ctrl_reg;
    end else if (ar_idx == IDX_STEP) begin
      rd_word = step_reg;
    end else if (ar_idx == IDX_STATUS) begin
      rd_word = status_word;
    end else if (ar_idx == IDX_CHANGE) begin
      rd_word[STAT_W-1:0] = change_reg;
    end else if (ar_idx == IDX_IO_LEVEL) begin
      rd_word[IO_LEVEL_BIT] = io_level_reg;
    end else if (idx_mapped(ar_idx)) begin
      rd_word = freq_reg[freq_rd_sel];
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_word;
      rresp_reg  <= idx_mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && S_AXI_RREADY) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  sequence s_up_only;
    up_pulse && !down_pulse && sel_ok && !wr_fire;
  endsequence
  sequence s_down_only;
    down_pulse && !up_pulse && sel_ok && !wr_fire;
  endsequence

  a_irq_after_change: assert property (|change_vec |-> ##2 !STATUS_CHANGE_IRQ_N)
    else $error("interrupt not low two cycles after a status change");
  a_reset_defaults: assert property (disable iff (1'b0)
      !RESETN |-> (ctrl_reg == CTRL_RESET) && (io_level_reg == IO_LEVEL_RESET))
    else $error("register not at default during reset");
  a_reset_outputs_off: assert property (disable iff (1'b0)
      !RESETN |-> CLK_OUT_ENABLE == '0)
    else $error("clock output enabled during reset");
  a_oe_pin_disable: assert property (oe_off_s |=> CLK_OUT_ENABLE == '0)
    else $error("outputs enabled while disable pin high");
  a_lock_pin_follow: assert property ($rose(stat_s[STAT_LOCK_BIT]) |=> PLL_LOCK_INDICATOR)
    else $error("lock indicator did not follow lock");
  a_input_lost_pin: assert property ($fell(stat_s[STAT_IN_LSB]) |=> !INPUT0_SIGNAL_LOST_N)
    else $error("input 0 lost indicator did not go low");
  a_ref_lost_pin: assert property ($fell(stat_s[STAT_REF_BIT]) |=> !REFERENCE_SIGNAL_LOST_N)
    else $error("reference lost indicator did not go low");
  a_step_up_word: assert property (s_up_only |=> sel_word == $past(sel_word) + $past(step_ext))
    else $error("step up did not add the step size");
  a_step_down_word: assert property (s_down_only |=> sel_word == $past(sel_word) - $past(step_ext))
    else $error("step down did not subtract the step size");
  a_manual_choice: assert property (manual_mode |=> ACTIVE_INPUT == $past(choice_s))
    else $error("active input differs from choice pins");
  a_io_level_write: assert property (wr_fire && wr_idx == IDX_IO_LEVEL && wstrb_reg[0]
      |=> IO_LEVEL_1V8 == $past(wdata_reg[IO_LEVEL_BIT]))
    else $error("level bit not taken from write");
  a_step_single_pulse: assert property (up_pulse |=> !up_pulse)
    else $error("step pulse longer than one cycle");
endmodule // ccsp_top
`default_nettype wire

// ===== tb/ccsp_host_model.sv
// Board logic model that drives the control and status inputs of the pin block
`timescale 1ns/100ps
`default_nettype none
module ccsp_host_model (
  input  wire logic        clk,  // Block clock
  input  wire logic [10:0] cmd,  // Wanted pin levels from the bench
  output logic      [10:0] pins  // Levels seen at the pins
);
  // Registered so every pin moves just after an edge, like real board logic
  always_ff @(posedge clk) begin
    pins <= cmd;
  end
endmodule // ccsp_host_model
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench of the control and status pin block
`timescale 1ns/100ps
`default_nettype none
module tb;
  import ccsp_pkg::*;
  logic          CLK = 0, RESETN = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic [15:0]   awa = '0, ara = '0;
  logic [31:0]   wd = '0, rdata;
  logic [10:0]   cmd = '0;
  wire logic [10:0] pins;
  wire logic [3:0]  l;
  logic [1:0]    bresp, rresp, act;
  logic          awr, wrdy, bv, arr, rv, irq, lk, rl, v18;
  logic [9:0]    en;
  logic [319:0]  fw;
  logic [33:0]   q[$];
  logic [31:0]   rs;
  int            error_cnt = 0, n_tests = 0;
  ccsp_host_model host_u (.clk(CLK), .cmd(cmd), .pins(pins));
  ccsp_top dut_u (.CLK(CLK), .RESETN(RESETN), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre),
    .OUTPUT_DISABLE_IN(pins[6]), .FREQ_STEP_UP_IN(pins[7]), .FREQ_STEP_DOWN_IN(pins[8]),
    .INPUT_CHOICE_BIT0(pins[9]), .INPUT_CHOICE_BIT1(pins[10]), .PLL_LOCKED_IN(pins[0]),
    .INPUT_CLK_PRESENT_IN(pins[4:1]), .REFERENCE_PRESENT_IN(pins[5]),
    .STATUS_CHANGE_IRQ_N(irq), .PLL_LOCK_INDICATOR(lk), .INPUT0_SIGNAL_LOST_N(l[0]),
    .INPUT1_SIGNAL_LOST_N(l[1]), .INPUT2_SIGNAL_LOST_N(l[2]), .INPUT3_SIGNAL_LOST_N(l[3]),
    .REFERENCE_SIGNAL_LOST_N(rl), .CLK_OUT_ENABLE(en), .ACTIVE_INPUT(act),
    .IO_LEVEL_1V8(v18), .OUT_FREQ_WORDS(fw));
  initial forever #2.5 CLK = ~CLK;
  task automatic chk(input string n, input logic [33:0] s, input logic [33:0] e);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic stop_test;
    $display("errors %0d, checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge CLK);
  endtask
  // One bus transfer; w high writes; expected response is queued for the monitor
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d,
                     input logic [1:0] r);
    logic [2:0] nx;
    logic       done;
    q.push_back({r, w ? 32'h0 : d});
    @(posedge CLK);
    {awa, ara, wd} <= {a, a, d};
    {awv, wv, bre, arv, rre} <= {w, w, w, !w, !w};
    do begin
      @(negedge CLK);
      nx = {awv & !awr, wv & !wrdy, arv & !arr};
      done = (bv & bre) | (rv & rre);
      @(posedge CLK);
      {awv, wv, arv} <= nx;
    end while (!done);
    {bre, rre} <= 2'b00;
  endtask
  // Handshake completes at the coming edge, so the response is settled now
  always @(negedge CLK) begin
    if ((bv & bre) | (rv & rre)) chk("bus", bv ? {bresp, 32'h0} : {rresp, rdata}, q.pop_front());
  end
  initial begin
    #20000;
    error_cnt++;
    stop_test();
  end
  initial begin
    // A real falling edge at time zero, so the asynchronous reset fires before any clock
    RESETN <= 1'b0;
    void'($urandom(2));
    @(negedge CLK);
    chk("en_rst", 34'(en), 34'h0);
    chk("irq_rst", 34'(irq), 34'h1);
    @(posedge CLK);
    @(posedge CLK) RESETN <= 1;
    bus(0, 16'h0000, CTRL_RESET, RESP_OKAY);
    bus(0, 16'h0004, STEP_RESET, RESP_OKAY);
    bus(1, 16'h250c, 32'h1, RESP_OKAY);
    w(2);
    chk("lvl", 34'(v18), 34'h1);
    bus(1, 16'h0200, 32'h5, RESP_SLVERR);
    bus(0, 16'h0200, 32'h0, RESP_SLVERR);
    @(posedge CLK) cmd[6] <= 1;
    w(6);
    chk("en_off", 34'(en), 34'h0);
    @(posedge CLK) cmd[6] <= 0;
    w(6);
    chk("en_on", 34'(en), 34'h3ff);
    rs = $urandom | 32'h1;
    @(posedge CLK) cmd[5:0] <= rs[5:0];
    w(8);
    chk("lock", 34'(lk), 34'(rs[0]));
    chk("lost", 34'(l), 34'(rs[4:1]));
    chk("ref", 34'(rl), 34'(rs[5]));
    chk("irq", 34'(irq), 34'h0);
    bus(1, 16'h000c, 32'h3f, RESP_OKAY);
    w(4);
    chk("irq_clr", 34'(irq), 34'h1);
    for (int i = 0; i < 4; i++) begin
      @(posedge CLK) cmd[10:9] <= 2'(i);
      w(6);
      chk("act", 34'(act), 34'(i));
    end
    // Automatic choice: lowest present input; enables follow the new control word
    bus(1, 16'h0000, 32'h0000_0155, RESP_OKAY);
    @(posedge CLK) cmd[4:1] <= 4'b0110;
    w(6);
    chk("act_auto", 34'(act), 34'h1);
    chk("en_cfg", 34'(en), 34'h155);
    bus(0, 16'h0008, {22'h0, 2'h1, 2'h0, rs[5], 4'h6, rs[0]}, RESP_OKAY);
    bus(0, 16'h000c, {26'h0, 1'b0, rs[4:1] ^ 4'h6, 1'b0}, RESP_OKAY);
    rs = $urandom;
    bus(1, 16'h0004, {8'h00, rs[15:0], 8'h02}, RESP_OKAY);
    @(posedge CLK) cmd[7] <= 1;
    w(12);
    chk("up", 34'(fw[95:64]), 34'(FREQ_RESET_DEF + rs[15:0]));
    @(posedge CLK) cmd[8:7] <= 2'b10;
    w(10);
    bus(0, 16'h0048, FREQ_RESET_DEF, RESP_OKAY);
    stop_test();
  end
endmodule // tb
`default_nettype wire
